// >>> design/mdc_dispatch_ctrl.sv
// Purpose: master dispatch control register and frame busy tracking
// Assumes: Avalon-MM slave, link events are one-cycle pulses
// Notes: interrupt status clears on read, a set in the same cycle wins
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`include "mdc_defines.svh"
`default_nettype none
module mdc_dispatch_ctrl #(
   parameter int BTO_CYC = `MDC_BTO_NS / `MDC_CLK_NS,
   parameter int SF_WAIT_CYC = `MDC_SF_WAIT_NS / `MDC_CLK_NS,
   parameter int TW = 18
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // link side
   input wire logic bus_master_enable,
   input wire mdc_pkg::mdc_link_in_t link_in,
   output mdc_pkg::mdc_link_out_t link_out,
   // interrupt
   output logic irq
);
   import mdc_pkg::*;

   localparam logic [TW-1:0] BTO_LOAD = TW'(BTO_CYC);
   localparam logic [TW-1:0] SF_LOAD = TW'(SF_WAIT_CYC);

   // register select by byte address
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
      return addr == ofs;
   endfunction

   // bus handshake: one wait cycle, then the request is taken
   logic ack_r;
   logic req_any;
   logic take;
   logic wr_take;
   logic rd_capture;
   logic sel_ctrl;
   logic sel_stat;
   logic sel_mask;
   logic wr_lo;
   logic wr_hi;
   logic mask_wr;

   assign req_any = avs_read || avs_write;
   assign avs_waitrequest = req_any && !ack_r;
   assign take = req_any && ack_r;
   assign wr_take = take && avs_write;
   // read data and clear-on-read share the first edge, so no status set slips between them
   assign rd_capture = avs_read && !ack_r;

   assign sel_ctrl = reg_hit(avs_address, `MDC_OFS_CTRL);
   assign sel_stat = reg_hit(avs_address, `MDC_OFS_IRQ_STAT);
   assign sel_mask = reg_hit(avs_address, `MDC_OFS_IRQ_MASK);

   assign wr_lo = wr_take && sel_ctrl && avs_byteenable[0];
   assign wr_hi = wr_take && sel_ctrl && avs_byteenable[1];

   assign mask_wr = wr_take && sel_mask && avs_byteenable[0];

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req_any && !ack_r;
      end
   end

   // write strobes per field
   logic [1:0] ea_wr;
   logic [1:0] ec_wr;
   logic cancel_frame_dispatch_wr;
   logic [1:0] req_wr;
   logic manual_wr;

   assign ea_wr = wr_hi ? avs_writedata[`MDC_EA_HI:`MDC_EA_LO] : 2'h0;
   assign ec_wr = wr_hi ? avs_writedata[`MDC_EC_HI:`MDC_EC_LO] : 2'h0;
   assign cancel_frame_dispatch_wr = wr_hi && avs_writedata[`MDC_CANCEL_FRAME_DISPATCH_BIT];
   assign req_wr = wr_lo ? avs_writedata[`MDC_REQ_HI:`MDC_REQ_LO] : 2'h0;
   assign manual_wr = wr_lo && avs_writedata[`MDC_MANUAL_BIT];

   // event announce and participation
   logic [1:0] ea_r;
   logic [1:0] ea_nxt;
   logic [1:0] par_r;
   logic [1:0] par_nxt;

   // announce only sets; cancel or a finished round clears it
   assign ea_nxt = (ea_r | ea_wr) & ~ec_wr & ~link_in.evt_done;
   // an announced type joins the round; the round's own set wins over cancel
   assign par_nxt = ((par_r & ~ec_wr) | (ea_r & link_in.evt_round)) & ~link_in.evt_done;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ea_r <= 2'h0;
         par_r <= 2'h0;
      end else begin
         ea_r <= ea_nxt;
         par_r <= par_nxt;
      end
   end

   // dispatch request field
   mdc_req_t req_r;
   mdc_req_t req_nxt;
   logic manual_r;
   logic manual_nxt;
   logic [4:0] size_r;
   logic tbl_evt;
   logic empty_done;
   logic auto_done;
   logic auto_run;

   // auto dispatch stays busy until its table ends or is cancelled
   assign auto_run = (req_r == MDC_REQ_AUTO);
   assign empty_done = (req_r == MDC_REQ_EMPTY) && link_in.timer1_zero;
   assign auto_done = auto_run && link_in.tbl_done;
   assign tbl_evt = !cancel_frame_dispatch_wr && (empty_done || auto_done);

   // one request at a time; cancel beats any write
   always_comb begin
      req_nxt = req_r;
      if (cancel_frame_dispatch_wr) begin
         req_nxt = MDC_REQ_NONE;
      end else if (req_r == MDC_REQ_NONE) begin
         req_nxt = mdc_req_t'(req_wr);
      end else if (req_r == MDC_REQ_TIMED && link_in.timer1_zero) begin
         req_nxt = MDC_REQ_AUTO;
      end else if (empty_done || auto_done) begin
         req_nxt = MDC_REQ_NONE;
      end
   end

   // manual request clears once its frame starts, or on cancel
   assign manual_nxt = cancel_frame_dispatch_wr ? 1'b0 :
      ((manual_r && !link_in.mf_tx_start) || manual_wr);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         req_r <= MDC_REQ_NONE;
         manual_r <= 1'b0;
         size_r <= 5'h00;
      end else begin
         req_r <= req_nxt;
         manual_r <= manual_nxt;
         if (wr_lo) begin
            size_r <= avs_writedata[`MDC_SIZE_HI:`MDC_SIZE_LO];
         end
      end
   end

   // frame flow: send, decoder check, slave frame wait
   mdc_state_t st_r;
   mdc_state_t st_nxt;
   logic tmr_load;
   logic [TW-1:0] tmr_val;
   logic tmr_stop;
   logic tmr_exp;
   logic bto_evt;
   logic bad_evt;
   logic sf_to_evt;

   // a decode in the expiry cycle wins over the bus timeout
   assign bto_evt = (st_r == MDC_ST_CHECK) && tmr_exp && !link_in.bad_mf && !link_in.mf_decoded;
   assign bad_evt = (st_r == MDC_ST_CHECK) && link_in.bad_mf;
   assign sf_to_evt = (st_r == MDC_ST_WAIT_SF) && tmr_exp && !link_in.sf_rx;

   always_comb begin
      st_nxt = st_r;
      tmr_load = 1'b0;
      tmr_val = BTO_LOAD;
      tmr_stop = 1'b0;
      case (st_r)
         MDC_ST_IDLE: begin
            if (link_in.mf_tx_start) begin
               st_nxt = MDC_ST_SEND;
            end
         end
         // a frame on the wire is always finished, even after cancel
         MDC_ST_SEND: begin
            if (link_in.mf_tx_done) begin
               st_nxt = MDC_ST_CHECK;
               tmr_load = 1'b1;
               tmr_val = BTO_LOAD;
            end
         end
         // bad frame first, then decode, then bus timeout
         MDC_ST_CHECK: begin
            if (link_in.bad_mf) begin
               st_nxt = MDC_ST_IDLE;
               tmr_stop = 1'b1;
            end else if (link_in.mf_decoded && link_in.sf_expected) begin
               st_nxt = MDC_ST_WAIT_SF;
               tmr_load = 1'b1;
               tmr_val = SF_LOAD;
            end else if (link_in.mf_decoded) begin
               st_nxt = MDC_ST_IDLE;
               tmr_stop = 1'b1;
            end else if (tmr_exp) begin
               st_nxt = MDC_ST_IDLE;
            end
         end
         MDC_ST_WAIT_SF: begin
            if (link_in.sf_rx) begin
               st_nxt = MDC_ST_IDLE;
               tmr_stop = 1'b1;
            end else if (tmr_exp) begin
               st_nxt = MDC_ST_IDLE;
            end
         end
         default: begin
            st_nxt = MDC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r <= MDC_ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // expiry pulses one cycle after the count ends; stop or load suppresses it
   mdc_wait_timer #(
      .W(TW)
   ) u_wait (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .load(tmr_load),
      .load_val(tmr_val),
      .stop(tmr_stop),
      .running(),
      .expired(tmr_exp)
   );

   // busy covers the frame in flight and any running auto dispatch
   logic busy;
   logic frame_idle;

   assign frame_idle = (st_r == MDC_ST_IDLE);
   assign busy = !frame_idle || manual_r || auto_run;

   // orders to the transmitter; nothing new is sent while cancel is written
   logic cancel_r;

   assign link_out.dispatch_go = bus_master_enable && frame_idle && !cancel_frame_dispatch_wr &&
      auto_run;
   assign link_out.manual_go = bus_master_enable && frame_idle && !cancel_frame_dispatch_wr && manual_r;
   assign link_out.cancel_pulse = cancel_r;
   assign link_out.table_size = size_r;
   assign link_out.event_participation = par_r;
   assign link_out.event_announce = ea_r;

   // cancel reaches the transmitter one cycle after its write
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cancel_r <= 1'b0;
      end else begin
         cancel_r <= cancel_frame_dispatch_wr;
      end
   end

   // interrupt status, mask and output
   logic [3:0] irq_set;
   logic [3:0] stat_r;
   logic [3:0] stat_nxt;
   logic [3:0] mask_r;
   logic stat_clr;

   assign irq_set[`MDC_IRQ_BTO] = bto_evt;
   assign irq_set[`MDC_IRQ_BAD_MF] = bad_evt;
   assign irq_set[`MDC_IRQ_TBL] = tbl_evt;
   assign irq_set[`MDC_IRQ_SF_TO] = sf_to_evt;

   // a set in the clearing cycle outlives the clear
   assign stat_clr = rd_capture && sel_stat;
   assign stat_nxt = (stat_clr ? 4'h0 : stat_r) | irq_set;
   assign irq = |(stat_r & mask_r);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stat_r <= `MDC_IRQ_RST;
         mask_r <= `MDC_IRQ_RST;
      end else begin
         stat_r <= stat_nxt;
         if (mask_wr) begin
            mask_r <= avs_writedata[3:0];
         end
      end
   end

   // read data; cancel bits and cancel-dispatch always read as zero
   logic [15:0] ctrl_view;
   logic [31:0] rd_mux;

   assign ctrl_view = {par_r, ea_r, 2'h0, busy, 1'b0, req_r, manual_r, size_r};

   always_comb begin
      if (sel_ctrl) begin
         rd_mux = {16'h0000, ctrl_view};
      end else if (sel_stat) begin
         rd_mux = {28'h0000000, stat_r};
      end else if (sel_mask) begin
         rd_mux = {28'h0000000, mask_r};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         avs_readdata <= 32'h00000000;
      end else if (rd_capture) begin
         avs_readdata <= rd_mux;
      end
   end

endmodule
`default_nettype wire

// >>> design/mdc_defines.svh
// Purpose: constants of the master dispatch control block
// Assumes: 100 MHz system clock
// Notes: byte addresses on the register bus
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH

// register byte addresses
`define MDC_OFS_CTRL 12'hfa0
`define MDC_OFS_IRQ_STAT 12'hfa4
`define MDC_OFS_IRQ_MASK 12'hfa8

// control register field positions
`define MDC_PAR_HI 15
`define MDC_PAR_LO 14
`define MDC_EA_HI 13
`define MDC_EA_LO 12
`define MDC_EC_HI 11
`define MDC_EC_LO 10
`define MDC_BUSY_BIT 9
`define MDC_CANCEL_FRAME_DISPATCH_BIT 8
`define MDC_REQ_HI 7
`define MDC_REQ_LO 6
`define MDC_MANUAL_BIT 5
`define MDC_SIZE_HI 4
`define MDC_SIZE_LO 0

// reset values
`define MDC_CTRL_RST 16'h0000
`define MDC_IRQ_RST 4'h0

// interrupt status bit positions
`define MDC_IRQ_BTO 0
`define MDC_IRQ_BAD_MF 1
`define MDC_IRQ_TBL 2
`define MDC_IRQ_SF_TO 3

// timing
`define MDC_CLK_NS 10
`define MDC_BTO_NS 1300000
`define MDC_SF_WAIT_NS 43000

`endif

// >>> design/mdc_pkg.sv
// Purpose: types of the master dispatch control block
// Assumes: nothing
// Notes: link signals travel as packed structs
`default_nettype none
package mdc_pkg;

   // dispatch request field codes
   typedef enum logic [1:0] {
      MDC_REQ_NONE = 2'h0,
      MDC_REQ_AUTO = 2'h1,
      MDC_REQ_TIMED = 2'h2,
      MDC_REQ_EMPTY = 2'h3
   } mdc_req_t;

   // frame flow, gray coded along idle-send-check-wait
   typedef enum logic [1:0] {
      MDC_ST_IDLE = 2'h0,
      MDC_ST_SEND = 2'h1,
      MDC_ST_CHECK = 2'h3,
      MDC_ST_WAIT_SF = 2'h2
   } mdc_state_t;

   // events from transmitter, decoder, timer and arbitration
   typedef struct packed {
      logic mf_tx_start;
      logic mf_tx_done;
      logic mf_decoded;
      logic sf_expected;
      logic sf_rx;
      logic bad_mf;
      logic timer1_zero;
      logic tbl_done;
      logic [1:0] evt_round;
      logic [1:0] evt_done;
   } mdc_link_in_t;

   // orders to the transmitter and arbitration
   typedef struct packed {
      logic dispatch_go;
      logic manual_go;
      logic cancel_pulse;
      logic [4:0] table_size;
      logic [1:0] event_participation;
      logic [1:0] event_announce;
   } mdc_link_out_t;

endpackage
`default_nettype wire

// >>> design/mdc_wait_timer.sv
// Purpose: down counter that times one wait and reports expiry
// Assumes: load and stop are one-cycle pulses
// Notes: expired is a registered one-cycle pulse
`default_nettype none
module mdc_wait_timer #(
   parameter int W = 18
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic stop,
   // status
   output logic running,
   output logic expired
);

   logic [W-1:0] cnt_r;
   logic run_r;
   logic exp_r;
   logic last;

   assign last = run_r && (cnt_r == {{(W-1){1'b0}}, 1'b1});
   assign running = run_r;
   assign expired = exp_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         exp_r <= 1'b0;
      end else begin
         exp_r <= last && !stop && !load;
         if (load) begin
            cnt_r <= load_val;
            run_r <= 1'b1;
         end else if (stop || last) begin
            cnt_r <= '0;
            run_r <= 1'b0;
         end else if (run_r) begin
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule
`default_nettype wire

// >>> tb/mdc_bus_model.sv
// Purpose: far side model, frame transmitter, decoder and slave answer
// Assumes: go levels from the block start one frame at a time
// Notes: mode 0 good frame, 1 no decode, 2 corrupt frame, 3 no slave frame
`default_nettype none
module mdc_bus_model
   import mdc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // link
   input wire mdc_pkg::mdc_link_out_t link_out,
   input wire logic [1:0] mode,
   output mdc_pkg::mdc_link_in_t fr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_r;
   // a started frame always runs to its end, cancel or not
   always_ff @(posedge clk_sys) begin
      fr <= '0;
      if (sys_rst) begin
         cnt_r <= 4'h0;
      end else if (cnt_r == 4'h0) begin
         if (link_out.dispatch_go | link_out.manual_go) begin
            cnt_r <= 4'h1;
         end
      end else begin
         cnt_r <= (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
         case (cnt_r)
            4'h2: fr.mf_tx_start <= 1'b1;
            4'h5: fr.mf_tx_done <= 1'b1;
            4'h6: begin
               fr.mf_decoded <= (mode == 2'h0) | (mode == 2'h3);
               fr.sf_expected <= 1'b1;
               fr.bad_mf <= (mode == 2'h2);
            end
            4'h9: fr.sf_rx <= (mode == 2'h0);
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> tb/mdc_dispatch_ctrl_sva.sv
// Purpose: port checker of the master dispatch control block
// Assumes: sees the top ports only
// Notes: bound at the foot of this file
`include "mdc_defines.svh"
`default_nettype none
module mdc_dispatch_ctrl_sva
   import mdc_pkg::*;
#(
   parameter int BTO_CYC = 20,
   parameter int SF_WAIT_CYC = 10
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // link side
   input wire logic bus_master_enable,
   input wire mdc_pkg::mdc_link_in_t link_in,
   input wire mdc_pkg::mdc_link_out_t link_out,
   // interrupt
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire ctrl_wr = avs_write && !avs_waitrequest && avs_address == `MDC_OFS_CTRL && avs_byteenable[1];
   wire ctrl_rd = avs_read && !avs_waitrequest && avs_address == `MDC_OFS_CTRL;
   wire go = link_out.dispatch_go || link_out.manual_go;
   property p_one_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest || !(avs_read || avs_write);
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("access took more than one wait state");
   property p_reset_clear;
      disable iff (1'b0) sys_rst |=> link_out == '0 && !irq;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
   property p_cancel_reads_zero;
      ctrl_rd |-> avs_readdata[11:10] == 2'h0;
   endproperty
   a_cancel_reads_zero: assert property (p_cancel_reads_zero) else $error("cancel bits read nonzero");
   property p_join_round;
      (link_out.event_participation & ~$past(link_out.event_participation)
         & ~$past(link_out.event_announce & link_in.evt_round)) == 2'h0;
   endproperty
   a_join_round: assert property (p_join_round) else $error("participation without announced round");
   property p_evt_cancel;
      ctrl_wr && avs_writedata[13:12] == 2'h0 && link_in.evt_round == 2'h0
         |=> ((link_out.event_announce | link_out.event_participation) & $past(avs_writedata[11:10])) == 2'h0;
   endproperty
   a_evt_cancel: assert property (p_evt_cancel) else $error("event cancel left a flag set");
   property p_dispatch_cancel;
      ctrl_wr && avs_writedata[8] && avs_writedata[7:5] == 3'h0 |=> link_out.cancel_pulse && !go;
   endproperty
   a_dispatch_cancel: assert property (p_dispatch_cancel) else $error("dispatch cancel not applied");
   property p_no_go_after_cancel;
      link_out.cancel_pulse && !avs_write |=> !go;
   endproperty
   a_no_go_after_cancel: assert property (p_no_go_after_cancel) else $error("frame ordered after cancel");
   property p_master_gate;
      !bus_master_enable |-> !go;
   endproperty
   a_master_gate: assert property (p_master_gate) else $error("frame ordered without bus mastering");
   property p_busy_after_start;
      link_in.mf_tx_start |=> !link_out.dispatch_go [*3];
   endproperty
   a_busy_after_start: assert property (p_busy_after_start) else $error("new frame ordered while busy");
   c_auto_go: cover property (link_out.dispatch_go);
   c_cancel: cover property (link_out.cancel_pulse);
   c_irq: cover property ($rose(irq));
endmodule
bind mdc_dispatch_ctrl mdc_dispatch_ctrl_sva #(.BTO_CYC(BTO_CYC), .SF_WAIT_CYC(SF_WAIT_CYC)) u_sva (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_master_enable(bus_master_enable),
   .link_in(link_in), .link_out(link_out), .irq(irq));
`default_nettype wire

// >>> tb/test_mdc_dispatch_ctrl.sv
// Purpose: self-checking bench of the master dispatch control block
// Assumes: one wait state per register access, short timer parameters
// Notes: frames come from the far side model
`include "mdc_defines.svh"
`default_nettype none
module test_mdc_dispatch_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import mdc_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic bus_master_enable = 1'b0;
   logic irq;
   logic [1:0] mode = 2'h0;
   mdc_link_in_t link_in;
   mdc_link_in_t fr;
   mdc_link_in_t tb_ev = '0;
   mdc_link_out_t link_out;
   logic [31:0] q;
   logic [31:0] st_exp [4] = '{32'h0, 32'h1, 32'h2, 32'h8};
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   assign link_in = fr | tb_ev;
   mdc_dispatch_ctrl #(.BTO_CYC(20), .SF_WAIT_CYC(10)) DUT (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bus_master_enable(bus_master_enable), .link_in(link_in), .link_out(link_out), .irq(irq));
   mdc_bus_model u_bus (.clk_sys(clk_sys), .sys_rst(sys_rst), .link_out(link_out), .mode(mode), .fr(fr));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   // request held until waitrequest is sampled low, then released for a cycle
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 16'h0000);
      chk(n, e, q);
   endtask
   task automatic pulse(input logic [11:0] v);
      tb_ev <= mdc_link_in_t'(v);
      @(posedge clk_sys);
      tb_ev <= '0;
      @(posedge clk_sys);
   endtask
   // polls busy with a bounded number of reads
   task automatic wait_idle();
      int i;
      i = 0;
      q = 32'h0000_0200;
      while (q[9] !== 1'b0 && i < 100) begin
         xfer(1'b0, `MDC_OFS_CTRL, 16'h0000);
         i++;
      end
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      rc("ctrl reset", `MDC_OFS_CTRL, 32'h0);
      rc("unmapped", 12'h100, 32'h0);
      rc("mask reset", `MDC_OFS_IRQ_MASK, 32'h0);
      wr(`MDC_OFS_CTRL, 16'h1000);
      wr(`MDC_OFS_CTRL, 16'h0000);
      rc("announce", `MDC_OFS_CTRL, 32'h1000);
      pulse(12'h00c);
      rc("participate 0", `MDC_OFS_CTRL, 32'h5000);
      wr(`MDC_OFS_CTRL, 16'h2000);
      pulse(12'h008);
      rc("participate 1", `MDC_OFS_CTRL, 32'hf000);
      chk("participation out", 32'h3, {30'h0, link_out.event_participation});
      wr(`MDC_OFS_CTRL, 16'h0400);
      rc("cancel 0", `MDC_OFS_CTRL, 32'ha000);
      wr(`MDC_OFS_CTRL, 16'h0800);
      rc("cancel 1", `MDC_OFS_CTRL, 32'h0);
      wr(`MDC_OFS_CTRL, 16'h1000);
      pulse(12'h004);
      pulse(12'h001);
      rc("round done", `MDC_OFS_CTRL, 32'h0);
      wr(`MDC_OFS_CTRL, 16'h001f);
      rc("table size", `MDC_OFS_CTRL, 32'h001f);
      chk("table size out", 32'h1f, {27'h0, link_out.table_size});
      wr(`MDC_OFS_CTRL, 16'h0000);
      wr(`MDC_OFS_CTRL, 16'h0020);
      repeat (20) @(posedge clk_sys);
      rc("manual held", `MDC_OFS_CTRL, 32'h0220);
      wr(`MDC_OFS_CTRL, 16'h0100);
      rc("manual cancelled", `MDC_OFS_CTRL, 32'h0);
      bus_master_enable <= 1'b1;
      wr(`MDC_OFS_IRQ_MASK, 16'h000f);
      wr(`MDC_OFS_CTRL, 16'h0040);
      wr(`MDC_OFS_CTRL, 16'h0080);
      rc("auto busy", `MDC_OFS_CTRL, 32'h0240);
      repeat (30) @(posedge clk_sys);
      pulse(12'h010);
      wait_idle();
      rc("auto done", `MDC_OFS_CTRL, 32'h0);
      chk("irq table", 32'h1, {31'h0, irq});
      rc("status table", `MDC_OFS_IRQ_STAT, 32'h4);
      rc("status cleared", `MDC_OFS_IRQ_STAT, 32'h0);
      wr(`MDC_OFS_CTRL, 16'h0080);
      rc("timed", `MDC_OFS_CTRL, 32'h0080);
      pulse(12'h020);
      rc("timed to auto", `MDC_OFS_CTRL, 32'h0240);
      wr(`MDC_OFS_CTRL, 16'h0100);
      wait_idle();
      rc("auto cancelled", `MDC_OFS_CTRL, 32'h0);
      wr(`MDC_OFS_CTRL, 16'h00c0);
      rc("empty", `MDC_OFS_CTRL, 32'h00c0);
      pulse(12'h020);
      rc("empty done", `MDC_OFS_CTRL, 32'h0);
      rc("status empty", `MDC_OFS_IRQ_STAT, 32'h4);
      for (int m = 0; m < 4; m++) begin
         mode <= m[1:0];
         wr(`MDC_OFS_CTRL, 16'h0020);
         wait_idle();
         chk("irq frame", {31'h0, m != 0}, {31'h0, irq});
         rc("status frame", `MDC_OFS_IRQ_STAT, st_exp[m]);
         chk("irq after read", 32'h0, {31'h0, irq});
      end
      wr(`MDC_OFS_IRQ_MASK, 16'h0000);
      mode <= 2'h2;
      wr(`MDC_OFS_CTRL, 16'h0020);
      wait_idle();
      chk("irq masked", 32'h0, {31'h0, irq});
      rc("status masked", `MDC_OFS_IRQ_STAT, 32'h2);
      stop_test();
   end
endmodule
`default_nettype wire
